// >>> alu_carry_pkg.sv
// Purpose: Constants and operation codes for the carry/accumulator/aux slice
// Assumes: Single core clock; operations decoded by the instruction decoder
// Notes:   Software reaches the carry, mode and pointer bits over APB
//
// Function
// [RULE_01] Arithmetic and one-bit shifts update carry only
// [RULE_02] Add/subtract with carry use prior carry
// [RULE_03] Add-high may only set carry
// [RULE_04] Subtract-high may only clear carry
// [RULE_05] Carry set and clear conditions evaluated
// [RULE_06] Force, clear, status load write carry
// [RULE_07] Hardware reset forces carry to one
// [RULE_08] 32-bit sum register, halves stored separately
// [RULE_09] Store path shifts left zero to seven
// [RULE_10] High store fills from low half
// [RULE_11] Low store fills zeros
// [RULE_12] One-bit shifts and rotates through carry
// [RULE_13] Right shift arithmetic when sign mode set
// [RULE_14] Left shift ignores sign mode
// [RULE_15] Repeat prefix reapplies shift operations
// [RULE_16] Eight aux registers, 3-bit pointer
// [RULE_17] Aux loadable from many sources, readable
// [RULE_18] Post-modify current aux by one or step
package alu_carry_pkg;

	// ****************************************************************
	// Operation codes
	// ****************************************************************
	typedef enum logic [4:0] {
		OP_NOP, OP_LOAD, OP_ADD, OP_SUB, OP_ADD_HIGH, OP_SUB_HIGH,
		OP_ADD_WITH_CARRY, OP_SUB_WITH_BORROW, OP_AND, OP_OR, OP_XOR,
		OP_LEFT_SHIFT, OP_RIGHT_SHIFT, OP_ROTATE_LEFT, OP_ROTATE_RIGHT,
		OP_CARRY_FORCE_ONE, OP_CARRY_FORCE_ZERO, OP_STATUS_LOAD
	} alu_op_t;

	typedef enum logic [1:0] {
		AUX_SRC_MEM, AUX_SRC_SUM, AUX_SRC_PRODUCT, AUX_SRC_IMM
	} aux_src_t;

	typedef enum logic [1:0] {
		POST_NONE, POST_INC, POST_DEC, POST_STEP
	} post_mod_t;

	// ****************************************************************
	// Register map and reset values
	// ****************************************************************
	localparam logic [11:0] CTRL_OFFSET    = 12'h000;
	localparam logic [11:0] STATUS_OFFSET  = 12'h004;
	localparam logic [11:0] SUM_OFFSET     = 12'h008;
	localparam int          CTRL_SXM_BIT   = 0;
	localparam int          STAT_CARRY_BIT = 0;
	localparam int          STAT_PTR_LSB   = 4;
	localparam int          STATUS_LD_CARRY_BIT = 9;
	localparam logic        CARRY_RESET    = 1'b1;
	localparam logic        SXM_RESET      = 1'b1;
	localparam logic [2:0]  PTR_RESET      = 3'h0;
	localparam logic [31:0] SUM_RESET      = 32'h0000_0000;
	localparam logic [15:0] AUX_RESET      = 16'h0000;
	localparam int          HIGH_SHIFT     = 16;

endpackage : alu_carry_pkg

// >>> carry_accumulator_aux_datapath.sv
// Purpose: Carry bit, sum register with store shifter, aux register file
// Assumes: Decoder issues at most one operation per cycle
// Notes:   All outputs registered
`timescale 1ns/100ps

module carry_accumulator_aux_datapath
	import alu_carry_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        op_valid,
	input  wire alu_op_t     alu_op,
	input  wire logic [31:0] operand,
	input  wire logic [15:0] status_word,
	input  wire logic [3:0]  repeat_count,
	input  wire logic        store_valid,
	input  wire logic        store_high,
	input  wire logic [2:0]  store_shift,
	input  wire logic        aux_load,
	input  wire aux_src_t    aux_src,
	input  wire logic [15:0] mem_data,
	input  wire logic [15:0] product_data,
	input  wire logic [15:0] imm_data,
	input  wire logic        ptr_load,
	input  wire logic        post_valid,
	input  wire post_mod_t   post_mod,
	input  wire logic [2:0]  aux_rd_sel,
	output logic      [31:0] sum_out,
	output logic             carry_out,
	output logic             cond_carry,
	output logic             cond_no_carry,
	output logic      [15:0] store_data,
	output logic             store_strobe,
	output logic      [15:0] aux_addr,
	output logic      [15:0] aux_rd_data,
	output logic      [2:0]  aux_pointer,
	output logic             repeat_busy
);

	// ****************************************************************
	// State
	// ****************************************************************
	logic [31:0] sum_register_reg;
	logic        carry_reg;
	logic        sign_extend_mode_bit_reg;
	logic [2:0]  aux_pointer_reg;
	logic [15:0] aux_register_file [8];
	logic [3:0]  rpt_left_reg;
	alu_op_t     rpt_op_reg;
	logic [15:0] store_data_reg;
	logic        store_strobe_reg;
	logic [31:0] prdata_reg;
	logic        pready_reg;

	// ****************************************************************
	// Central ALU
	// ****************************************************************
	alu_op_t     act_op;
	logic        act_valid;
	logic [32:0] sum_ext;
	logic [32:0] diff_ext;
	logic [32:0] add_with_carry_op_ext;
	logic [32:0] subtract_with_borrow_op_ext;
	logic [32:0] hadd_ext;
	logic [32:0] hsub_ext;
	logic [31:0] sum_next;
	logic        carry_next;
	logic        shift_top;

	// A held repeat replaces the decoder op until its count runs out
	assign act_valid = (rpt_left_reg != 4'h0) || op_valid; // RULE_15
	assign act_op    = (rpt_left_reg != 4'h0) ? rpt_op_reg : alu_op;

	assign sum_ext  = {1'b0, sum_register_reg} + {1'b0, operand};
	assign diff_ext = {1'b0, sum_register_reg} - {1'b0, operand};
	assign add_with_carry_op_ext = sum_ext + {32'h0, carry_reg}; // RULE_02
	assign subtract_with_borrow_op_ext = diff_ext - {32'h0, ~carry_reg}; // RULE_02
	assign hadd_ext = {1'b0, sum_register_reg}
	                + {1'b0, operand[15:0], 16'h0000};
	assign hsub_ext = {1'b0, sum_register_reg}
	                - {1'b0, operand[15:0], 16'h0000};
	// Sign bit kept only in sign-extend mode
	assign shift_top = sign_extend_mode_bit_reg & sum_register_reg[31]; // RULE_13

	always_comb begin
		sum_next   = sum_register_reg;
		carry_next = carry_reg;
		if (act_valid) begin
			case (act_op)
			OP_LOAD:  sum_next = operand; // RULE_01
			OP_AND:   sum_next = sum_register_reg & operand;
			OP_OR:    sum_next = sum_register_reg | operand;
			OP_XOR:   sum_next = sum_register_reg ^ operand;
			OP_ADD: begin
				sum_next   = sum_ext[31:0]; // RULE_08
				carry_next = sum_ext[32]; // RULE_01
			end
			OP_SUB: begin
				sum_next   = diff_ext[31:0];
				carry_next = ~diff_ext[32];
			end
			OP_ADD_WITH_CARRY: begin
				sum_next   = add_with_carry_op_ext[31:0];
				carry_next = add_with_carry_op_ext[32];
			end
			OP_SUB_WITH_BORROW: begin
				sum_next   = subtract_with_borrow_op_ext[31:0];
				carry_next = ~subtract_with_borrow_op_ext[32];
			end
			OP_ADD_HIGH: begin
				sum_next = hadd_ext[31:0];
				if (hadd_ext[32])
					carry_next = 1'b1; // RULE_03
			end
			OP_SUB_HIGH: begin
				sum_next = hsub_ext[31:0];
				if (hsub_ext[32])
					carry_next = 1'b0; // RULE_04
			end
			OP_LEFT_SHIFT: begin
				sum_next   = {sum_register_reg[30:0], 1'b0}; // RULE_14
				carry_next = sum_register_reg[31]; // RULE_12
			end
			OP_RIGHT_SHIFT: begin
				sum_next   = {shift_top, sum_register_reg[31:1]}; // RULE_13
				carry_next = sum_register_reg[0]; // RULE_12
			end
			OP_ROTATE_LEFT: begin
				sum_next   = {sum_register_reg[30:0], carry_reg}; // RULE_12
				carry_next = sum_register_reg[31];
			end
			OP_ROTATE_RIGHT: begin
				sum_next   = {carry_reg, sum_register_reg[31:1]}; // RULE_12
				carry_next = sum_register_reg[0];
			end
			OP_CARRY_FORCE_ONE:  carry_next = 1'b1; // RULE_06
			OP_CARRY_FORCE_ZERO: carry_next = 1'b0; // RULE_06
			OP_STATUS_LOAD:
				carry_next = status_word[STATUS_LD_CARRY_BIT]; // RULE_06
			default: begin
				sum_next   = sum_register_reg;
				carry_next = carry_reg;
			end
			endcase
		end
	end

	// ****************************************************************
	// Repeat facility
	// ****************************************************************
	logic       rpt_start;
	logic [3:0] rpt_left_next;

	// Only shift and rotate ops may be repeated; others run once
	assign rpt_start = op_valid && (rpt_left_reg == 4'h0)
	                && (repeat_count != 4'h0)
	                && (alu_op inside {OP_LEFT_SHIFT, OP_RIGHT_SHIFT,
	                                   OP_ROTATE_LEFT, OP_ROTATE_RIGHT});
	assign rpt_left_next = rpt_start ? repeat_count
	                     : (rpt_left_reg != 4'h0) ? rpt_left_reg - 4'h1
	                     : 4'h0; // RULE_15

	// ****************************************************************
	// Store shifter
	// ****************************************************************
	logic [47:0] store_wide;
	logic [15:0] store_next;

	// Shifting a 48-bit window gives the high-half fill for free
	assign store_wide = store_high ? {16'h0000, sum_register_reg} << store_shift
	                  : {32'h0, sum_register_reg[15:0]} << store_shift;
	assign store_next = store_high ? store_wide[31:16] // RULE_10
	                  : store_wide[15:0]; // RULE_11

	// ****************************************************************
	// Address arithmetic unit
	// ****************************************************************
	logic [15:0] aux_cur;
	logic [15:0] aux_post;
	logic [15:0] aux_load_val;

	assign aux_cur = aux_register_file[aux_pointer_reg]; // RULE_16
	always_comb begin
		case (post_mod)
		POST_INC:  aux_post = aux_cur + 16'h0001; // RULE_18
		POST_DEC:  aux_post = aux_cur - 16'h0001; // RULE_18
		POST_STEP: aux_post = aux_cur + aux_register_file[0]; // RULE_18
		default:   aux_post = aux_cur;
		endcase
	end

	always_comb begin
		case (aux_src)
		AUX_SRC_MEM:     aux_load_val = mem_data; // RULE_17
		AUX_SRC_SUM:     aux_load_val = sum_register_reg[15:0]; // RULE_17
		AUX_SRC_PRODUCT: aux_load_val = product_data; // RULE_17
		AUX_SRC_IMM:     aux_load_val = imm_data; // RULE_17
		default:         aux_load_val = mem_data;
		endcase
	end

	// ****************************************************************
	// APB slave
	// ****************************************************************
	logic        apb_setup;
	logic        apb_wr;
	logic        apb_rd;
	logic        hit_ctrl;
	logic        hit_status;
	logic        hit_sum;
	logic [31:0] rd_mux;

	assign apb_setup  = psel && !penable;
	assign apb_wr     = psel && penable && pready_reg && pwrite;
	assign apb_rd     = apb_setup && !pwrite;
	assign hit_ctrl   = (paddr == CTRL_OFFSET);
	assign hit_status = (paddr == STATUS_OFFSET);
	assign hit_sum    = (paddr == SUM_OFFSET);
	assign rd_mux = hit_ctrl ? {31'h0, sign_extend_mode_bit_reg}
	       : hit_status ? {25'h0, aux_pointer_reg, 3'h0, carry_reg}
	       : hit_sum ? sum_register_reg
	       : 32'h0000_0000;

	// ****************************************************************
	// Sum register and carry
	// ****************************************************************
	// Carry is the one bit here that reset forces high
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sum_register_reg <= SUM_RESET;
			carry_reg        <= CARRY_RESET; // RULE_07
		end else begin
			sum_register_reg <= sum_next;
			carry_reg        <= carry_next;
		end
	end

	// ****************************************************************
	// Repeat counter
	// ****************************************************************
	// The op is latched once so the decoder may move on while it runs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rpt_left_reg <= 4'h0;
			rpt_op_reg   <= OP_NOP;
		end else begin
			rpt_left_reg <= rpt_left_next; // RULE_15
			if (rpt_start)
				rpt_op_reg <= alu_op;
		end
	end

	// ****************************************************************
	// Sign-extension mode
	// ****************************************************************
	// Only software changes the mode, through the control word
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			sign_extend_mode_bit_reg <= SXM_RESET;
		else if (apb_wr && hit_ctrl)
			sign_extend_mode_bit_reg <= pwdata[CTRL_SXM_BIT];
	end

	// ****************************************************************
	// Auxiliary register file and pointer
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 8; i++)
				aux_register_file[i] <= AUX_RESET;
		end else begin
			if (post_valid)
				aux_register_file[aux_pointer_reg] <= aux_post; // RULE_18
			// Explicit loads win over a same-cycle post-modify
			if (aux_load)
				aux_register_file[aux_rd_sel] <= aux_load_val; // RULE_17
		end
	end

	// A decoder load beats a software write in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			aux_pointer_reg <= PTR_RESET;
		else if (ptr_load)
			aux_pointer_reg <= aux_load_val[2:0]; // RULE_16
		else if (apb_wr && hit_status)
			aux_pointer_reg <= pwdata[STAT_PTR_LSB +: 3];
	end

	// ****************************************************************
	// Store port
	// ****************************************************************
	// Data holds its last value between strobes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			store_data_reg   <= 16'h0000;
			store_strobe_reg <= 1'b0;
		end else begin
			store_strobe_reg <= store_valid;
			if (store_valid)
				store_data_reg <= store_next; // RULE_09
		end
	end

	// ****************************************************************
	// Bus answer
	// ****************************************************************
	logic        pslverr_reg;

	// No access is refused: unmapped reads give zero, writes vanish
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg  <= 32'h0000_0000;
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			pready_reg  <= apb_setup;
			pslverr_reg <= 1'b0;
			if (apb_rd)
				prdata_reg <= rd_mux;
		end
	end

	// ****************************************************************
	// State mirrors
	// ****************************************************************
	// Mirrors take the next value so they match the state after the edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sum_out       <= SUM_RESET;
			carry_out     <= CARRY_RESET;
			cond_carry    <= CARRY_RESET;
			cond_no_carry <= ~CARRY_RESET;
			repeat_busy   <= 1'b0;
		end else begin
			sum_out       <= sum_next; // RULE_08
			carry_out     <= carry_next;
			cond_carry    <= carry_next; // RULE_05
			cond_no_carry <= ~carry_next; // RULE_05
			repeat_busy   <= (rpt_left_next != 4'h0);
		end
	end

	// ****************************************************************
	// Auxiliary outputs
	// ****************************************************************
	// Both lag the file by one cycle; the decoder allows for it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			aux_addr    <= AUX_RESET;
			aux_rd_data <= AUX_RESET;
		end else begin
			aux_addr    <= aux_cur;
			aux_rd_data <= aux_register_file[aux_rd_sel]; // RULE_17
		end
	end

	// ****************************************************************
	// Output wiring
	// ****************************************************************
	assign store_data   = store_data_reg;
	assign store_strobe = store_strobe_reg;
	assign prdata       = prdata_reg;
	assign pready       = pready_reg;
	assign pslverr      = pslverr_reg;
	assign aux_pointer  = aux_pointer_reg;

endmodule : carry_accumulator_aux_datapath

// >>> datapath_checker.sv
// Purpose: Concurrent checks on carry, store and shift outputs
// Assumes: No store in the same cycle as an operation
// Notes: Sees top-level ports only; bound below
`timescale 1ns/100ps
module datapath_checker
	import alu_carry_pkg::*;
(
	input wire logic	pclk,
	input wire logic	presetn,
	input wire logic	op_valid,
	input wire alu_op_t	alu_op,
	input wire logic [15:0]	status_word,
	input wire logic [3:0]	repeat_count,
	input wire logic	store_valid,
	input wire logic	store_high,
	input wire logic [2:0]	store_shift,
	input wire logic [31:0]	sum_out,
	input wire logic	carry_out,
	input wire logic [15:0]	store_data,
	input wire logic	store_strobe,
	input wire logic	repeat_busy
);
	// ****
	// Helpers
	// ****
	wire logic [31:0] st_wide = sum_out << store_shift;
	wire logic [15:0] st_exp = store_high ? st_wide[31:16] : st_wide[15:0];
	wire logic sw_c = status_word[STATUS_LD_CARRY_BIT];
	wire logic msb = sum_out[31];
	// Repeats in flight may still be shifting, so they are excluded
	wire logic no_arith = op_valid && !repeat_busy &&
		alu_op inside {OP_NOP, OP_LOAD, OP_AND, OP_OR, OP_XOR};
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// ****
	// Properties
	// ****
	property p_keep;
		no_arith |=> $stable(carry_out);
	endproperty
	a_keep: assert property (p_keep) else $error("carry moved");
	property p_add_high;
		op_valid && alu_op == OP_ADD_HIGH |=> carry_out || !$past(carry_out);
	endproperty
	a_add_high: assert property (p_add_high) else $error("add cleared");
	property p_sub_high;
		op_valid && alu_op == OP_SUB_HIGH |=> !carry_out || $past(carry_out);
	endproperty
	a_sub_high: assert property (p_sub_high) else $error("sub set");
	property p_force;
		op_valid && alu_op == OP_CARRY_FORCE_ONE |=> carry_out;
	endproperty
	a_force: assert property (p_force) else $error("force failed");
	property p_status;
		op_valid && alu_op == OP_STATUS_LOAD |=> carry_out == $past(sw_c);
	endproperty
	a_status: assert property (p_status) else $error("load failed");
	property p_reset;
		disable iff (1'b0) $rose(presetn) |-> carry_out;
	endproperty
	a_reset: assert property (p_reset) else $error("reset carry");
	property p_store;
		store_valid |=> store_strobe && store_data == $past(st_exp);
	endproperty
	a_store: assert property (p_store) else $error("store data");
	property p_left;
		op_valid && alu_op == OP_LEFT_SHIFT && repeat_count == 4'h0
		|=> sum_out == $past(sum_out) << 1 && carry_out == $past(msb);
	endproperty
	a_left: assert property (p_left) else $error("left shift");
	property p_repeat;
		op_valid && repeat_count == 4'h3 && alu_op inside {OP_LEFT_SHIFT,
			OP_RIGHT_SHIFT, OP_ROTATE_LEFT, OP_ROTATE_RIGHT}
		|=> repeat_busy [*3] ##1 !repeat_busy;
	endproperty
	a_repeat: assert property (p_repeat) else $error("repeat len");
endmodule : datapath_checker
bind carry_accumulator_aux_datapath datapath_checker u_chk (.pclk, .presetn,
	.op_valid, .alu_op, .status_word, .repeat_count, .store_valid,
	.store_high, .store_shift, .sum_out, .carry_out, .store_data,
	.store_strobe, .repeat_busy);

// >>> tb_top.sv
// Purpose: Self-checking bench for the carry, sum and aux datapath
// Assumes: One operation at a time; APB answers with no wait state
// Notes: Drivers queue notes; watchers pop them as results show
`timescale 1ns/100ps
module tb_top
	import alu_carry_pkg::*;
;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, op_valid = 1'b0, store_valid = 1'b0;
	logic store_high = 1'b0, aux_load = 1'b0, ptr_load = 1'b0;
	logic post_valid = 1'b0, pready, pslverr, carry_out, cond_carry;
	logic cond_no_carry, store_strobe, repeat_busy, c_m, sxm_m;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, operand = 32'h0, prdata, sum_out, sum_m;
	logic [31:0] rs = 32'h4b8c;
	logic [15:0] status_word = 16'h0, mem_data = 16'h0, imm_data = 16'h0;
	logic [15:0] product_data = 16'h0, store_data, aux_addr, aux_rd_data;
	logic [15:0] aux_m [8];
	logic [3:0] repeat_count = 4'h0;
	logic [2:0] store_shift = 3'h0, aux_rd_sel = 3'h0, aux_pointer, ptr_m;
	alu_op_t alu_op = OP_NOP;
	aux_src_t aux_src = AUX_SRC_MEM;
	post_mod_t post_mod = POST_NONE;
	logic [34:0] q_alu [$];
	logic [15:0] q_st [$];
	int fails = 0;
	int n_tests = 0;
	event alu_done;
	carry_accumulator_aux_datapath dut (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .op_valid,
		.alu_op, .operand, .status_word, .repeat_count, .store_valid,
		.store_high, .store_shift, .aux_load, .aux_src, .mem_data,
		.product_data, .imm_data, .ptr_load, .post_valid, .post_mod,
		.aux_rd_sel, .sum_out, .carry_out, .cond_carry, .cond_no_carry,
		.store_data, .store_strobe, .aux_addr, .aux_rd_data, .aux_pointer,
		.repeat_busy);
	always #12.5 pclk = ~pclk;
	// ****
	// Checking
	// ****
	task end_of_test;
		if (fails == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_of_test
	task fail_out;
		fails++;
		end_of_test();
	endtask : fail_out
	task chk(input logic [34:0] got, input logic [34:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	always @(alu_done)
		chk({sum_out, carry_out, cond_carry, cond_no_carry}, q_alu.pop_front());
	always @(negedge pclk)
		if (store_strobe === 1'b1)
			chk(store_data, q_st.pop_front());
	function logic [31:0] rnd();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction : rnd
	// ****
	// Drivers
	// ****
	task do_reset;
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (8) @(posedge pclk);
		chk({sum_out, carry_out, cond_carry, cond_no_carry},
			{SUM_RESET, CARRY_RESET, CARRY_RESET, ~CARRY_RESET});
		presetn <= 1'b1;
		{c_m, sxm_m, sum_m, ptr_m} = 37'h18_0000_0000;
		aux_m = '{default: 16'h0};
	endtask : do_reset
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, e);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20)
			fail_out();
		chk(35'(pslverr), 35'h0);
		if (!w)
			chk(prdata, e);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task model(input alu_op_t o, input logic [31:0] v);
		logic [32:0] t;
		t = {c_m, sum_m};
		case (o)
			OP_LOAD: t[31:0] = v;
			OP_ADD: t = sum_m + v;
			OP_SUB: t = {sum_m >= v, sum_m - v};
			OP_ADD_HIGH: t = {c_m, 32'h0} | (sum_m + {v[15:0], 16'h0});
			OP_SUB_HIGH: t = {c_m & (sum_m >= {v[15:0], 16'h0}),
				sum_m - {v[15:0], 16'h0}};
			OP_ADD_WITH_CARRY: t = sum_m + v + c_m;
			OP_SUB_WITH_BORROW: t = {{1'b0, sum_m} >= v + !c_m, sum_m - v - !c_m};
			OP_AND: t[31:0] = sum_m & v;
			OP_OR: t[31:0] = sum_m | v;
			OP_XOR: t[31:0] = sum_m ^ v;
			OP_LEFT_SHIFT: t = {sum_m, 1'b0};
			OP_RIGHT_SHIFT: t = {sum_m[0], sxm_m & sum_m[31], sum_m[31:1]};
			OP_ROTATE_LEFT: t = {sum_m, c_m};
			OP_ROTATE_RIGHT: t = {sum_m[0], c_m, sum_m[31:1]};
			OP_CARRY_FORCE_ONE: t[32] = 1'b1;
			OP_CARRY_FORCE_ZERO: t[32] = 1'b0;
			OP_STATUS_LOAD: t[32] = v[STATUS_LD_CARRY_BIT];
			default: ;
		endcase
		{c_m, sum_m} = t;
	endtask : model
	task op(input alu_op_t o, input logic [31:0] v, input logic [3:0] n);
		int k;
		@(posedge pclk);
		op_valid <= 1'b1;
		alu_op <= o;
		operand <= v;
		status_word <= v[15:0];
		repeat_count <= n;
		for (k = 0; k <= n; k++)
			model(o, v);
		@(posedge pclk);
		op_valid <= 1'b0;
		k = 0;
		do begin
			@(negedge pclk);
			k++;
		end while (repeat_busy !== 1'b0 && k < 20);
		if (k >= 20)
			fail_out();
		q_alu.push_back({sum_m, c_m, c_m, !c_m});
		->alu_done;
	endtask : op
	task store(input logic h, input logic [2:0] s);
		logic [31:0] t;
		t = sum_m << s;
		@(posedge pclk);
		store_valid <= 1'b1;
		store_high <= h;
		store_shift <= s;
		q_st.push_back(h ? t[31:16] : t[15:0]);
		@(posedge pclk);
		store_valid <= 1'b0;
	endtask : store
	task aux(input logic l, p, input aux_src_t s, input logic [2:0] i,
		input logic [15:0] v, input post_mod_t m);
		logic [15:0] sv;
		sv = (s == AUX_SRC_MEM) ? v : (s == AUX_SRC_SUM) ? sum_m[15:0] :
			(s == AUX_SRC_PRODUCT) ? ~v : v ^ 16'h5a5a;
		@(posedge pclk);
		{aux_load, ptr_load, aux_src, aux_rd_sel, post_mod} <= {l, p, s, i, m};
		{mem_data, product_data, imm_data} <= {v, ~v, v ^ 16'h5a5a};
		post_valid <= m != POST_NONE;
		case (m)
			POST_INC: aux_m[ptr_m] += 16'h1;
			POST_DEC: aux_m[ptr_m] -= 16'h1;
			POST_STEP: aux_m[ptr_m] += aux_m[0];
			default: ;
		endcase
		if (l)
			aux_m[i] = sv;
		if (p)
			ptr_m = sv[2:0];
		@(posedge pclk);
		{aux_load, ptr_load, post_valid} <= 3'h0;
	endtask : aux
	task rd(input logic [2:0] i);
		@(posedge pclk);
		aux_rd_sel <= i;
		@(posedge pclk);
		@(negedge pclk);
		chk({aux_addr, aux_pointer, aux_rd_data}, {aux_m[ptr_m], ptr_m, aux_m[i]});
	endtask : rd
	// ****
	// Scenarios
	// ****
	initial begin
		int i;
		logic [31:0] r;
		do_reset();
		apb(1'b0, CTRL_OFFSET, 32'h0, 32'h1);
		apb(1'b1, STATUS_OFFSET, 32'h50, 32'h0);
		ptr_m = 3'h5;
		apb(1'b1, 12'h00c, 32'hffff_ffff, 32'h0);
		apb(1'b0, 12'h00c, 32'h0, 32'h0);
		apb(1'b0, STATUS_OFFSET, 32'h0, 32'h51);
		op(OP_CARRY_FORCE_ZERO, 32'h0, 4'h0);
		op(OP_LOAD, 32'hffff_0000, 4'h0);
		op(OP_ADD_HIGH, 32'h1, 4'h0);
		op(OP_CARRY_FORCE_ZERO, 32'h0, 4'h0);
		op(OP_ADD_HIGH, 32'h1, 4'h0);
		op(OP_SUB_HIGH, 32'h1, 4'h0);
		op(OP_SUB_HIGH, 32'h1, 4'h0);
		op(OP_CARRY_FORCE_ONE, 32'h0, 4'h0);
		op(OP_SUB_HIGH, 32'h1, 4'h0);
		op(OP_STATUS_LOAD, 32'h0, 4'h0);
		op(OP_SUB_WITH_BORROW, 32'h5, 4'h0);
		op(OP_ADD_WITH_CARRY, 32'h7fff_ffff, 4'h0);
		op(OP_LOAD, 32'h8000_0001, 4'h0);
		op(OP_RIGHT_SHIFT, 32'h0, 4'h0);
		op(OP_ROTATE_RIGHT, 32'h0, 4'h0);
		op(OP_LEFT_SHIFT, 32'h0, 4'h0);
		op(OP_ROTATE_LEFT, 32'h0, 4'h0);
		apb(1'b1, CTRL_OFFSET, 32'h0, 32'h0);
		sxm_m = 1'b0;
		op(OP_LOAD, 32'h8000_0000, 4'h0);
		op(OP_RIGHT_SHIFT, 32'h0, 4'h3);
		op(OP_LEFT_SHIFT, 32'h0, 4'h3);
		op(OP_ROTATE_RIGHT, 32'h0, 4'h2);
		for (i = 0; i < 72; i++) begin
			r = rnd();
			op(alu_op_t'(i % 18), r, 4'h0);
		end
		for (i = 0; i < 16; i++)
			store(i[0], i[3:1]);
		apb(1'b0, SUM_OFFSET, 32'h0, sum_m);
		for (i = 0; i < 8; i++) begin
			r = rnd();
			aux(1'b1, 1'b0, aux_src_t'(i[1:0]), i[2:0], r[15:0], POST_NONE);
			rd(i[2:0]);
		end
		aux(1'b0, 1'b1, AUX_SRC_IMM, 3'h0, 16'h6, POST_NONE);
		rd(3'h1);
		for (i = 1; i < 4; i++) begin
			aux(1'b0, 1'b0, AUX_SRC_MEM, 3'h0, 16'h0, post_mod_t'(i[1:0]));
			rd(3'h0);
		end
		op(OP_CARRY_FORCE_ZERO, 32'h0, 4'h0);
		do_reset();
		chk(35'(q_st.size() + q_alu.size()), 35'h0);
		end_of_test();
	end
endmodule : tb_top
